/* File: rtl/maint_menu.sv */
/*
 * maintenance menu controller: button-driven routine selection, persistent settings,
 * counters, transfer start, bus terminator handling; registers over APB.
 * assumes button and bus inputs are one-cycle pulses synchronous to MCLK.
 */
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module maint_menu
   import menu_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        BTN_VCURSOR,
   input  wire logic        BTN_TCURSOR,
   input  wire logic        BTN_SLOPE,
   input  wire logic        BTN_MODE_UP,
   input  wire logic        BTN_MODE_DN,
   input  wire logic        BTN_CPL_UP,
   input  wire logic        BTN_CPL_DN,
   input  wire logic        TRIGGER_SELECT_BUTTON,
   input  wire logic        MENU_SELECT_BUTTON,
   input  wire logic        COUNTER_TIMER_OPTION,
   input  wire logic        DELTA_UP,
   input  wire logic        DELTA_DN,
   input  wire logic        SRC_UP,
   input  wire logic        SRC_DN,
   input  wire logic        HOUR_TICK,
   input  wire logic        XFER_BEGIN,
   input  wire logic        XFER_DONE,
   input  wire logic        RX_VALID,
   input  wire logic [7:0]  RX_BYTE,
   input  wire logic        RX_EOI,
   input  wire logic        CPL_AC_TO_TV,
   input  wire logic [4:0]  SAVE_SLOT,
   input  wire logic        SEQ_EDIT,
   output logic      [2:0]  DISP_MODE,
   output logic      [3:0]  DISP_ROUTINE,
   output logic             DISP_TONE_PHASE,
   output logic             PWRUP_LAST,
   output logic      [1:0]  PROT_MODE,
   output logic             SAVE_OK,
   output logic             ERASE_SETUPS,
   output logic      [4:0]  BUS_ADDR,
   output logic             BUS_IGNORE,
   output logic             TALK_ENABLE,
   output logic             RX_MSG_END,
   output logic             TX_CRLF,
   output logic             XFER_START,
   output logic             XFER_SEND,
   output logic      [1:0]  LINE_LEAD,
   output logic             FIELD1_ONLY,
   output logic             SLOPE_SET,
   output logic             SLOPE_POS,
   output logic             METER_HIZ,
   output logic      [3:0]  TONE_PITCH,
   output logic      [13:0] HOURS,
   output logic      [13:0] CYCLES,
   output logic             NV_SAVE
);
   state_t       s_reg;
   state_t       s_next;
   logic         exit_btn;
   logic         apb_go;
   logic [31:0]  set_word;
   logic         set_changed;

   assign exit_btn = TRIGGER_SELECT_BUTTON | (MENU_SELECT_BUTTON & COUNTER_TIMER_OPTION);
   assign apb_go   = PSEL & PENABLE & s_reg.pready;

   always_comb begin
      set_word = '0;
      set_word[F_PWR]              = s_reg.pwr_last;
      set_word[F_PROT +: 2]        = s_reg.prot;
      set_word[F_ADDR +: 5]        = s_reg.addr;
      set_word[F_LF]               = s_reg.term_lf;
      set_word[F_LONLY]            = s_reg.listen_only;
      set_word[F_SYSM]             = s_reg.sys_m;
      set_word[F_FLD1]             = s_reg.field1_only;
      set_word[F_SYNC +: 2]        = s_reg.sync_pol;
      set_word[F_HIZ]              = s_reg.hiz;
      set_word[F_TONE +: 4]        = s_reg.tone;
   end

   always_comb begin
      s_next           = s_reg;
      s_next.erase     = 1'b0;
      s_next.xstart    = 1'b0;
      s_next.slope_set = 1'b0;
      // menu sequencing
      unique case (s_reg.mode)
         M_NORMAL: begin
            if (BTN_SLOPE && BTN_VCURSOR && BTN_TCURSOR) begin
               s_next.mode = M_SELECT;
               s_next.rtn  = RT_HOURS;
            end
         end
         M_SELECT: begin
            if (exit_btn) begin
               s_next.mode = M_NORMAL;
            end else if (BTN_MODE_UP) begin
               s_next.rtn = (s_reg.rtn == RT_LAST) ? RT_HOURS : s_reg.rtn + 4'h1;
            end else if (BTN_MODE_DN) begin
               s_next.rtn = (s_reg.rtn == RT_HOURS) ? RT_LAST : s_reg.rtn - 4'h1;
            end else if (BTN_CPL_UP) begin
               s_next.tone_phase = 1'b1;
               if (s_reg.rtn == RT_RECV) begin
                  s_next.mode = M_RXREADY;
               end else if (s_reg.rtn == RT_SEND) begin
                  if (!s_reg.ignore && !s_reg.listen_only) begin
                     s_next.mode   = M_TXBUSY;
                     s_next.xstart = 1'b1;
                     s_next.xsend  = 1'b1;
                  end
               end else begin
                  s_next.mode = M_RUN;
               end
            end
         end
         M_RUN: begin
            if (exit_btn) begin
               s_next.mode = M_NORMAL;
            end else if (BTN_CPL_DN) begin
               s_next.mode = M_SELECT;
            end else begin
               unique case (s_reg.rtn)
                  RT_PWRUP: if (BTN_CPL_UP) s_next.pwr_last = ~s_reg.pwr_last;
                  RT_PROT: begin
                     if (BTN_CPL_UP) begin
                        s_next.prot = (s_reg.prot == PROT_LOW8) ? PROT_ALL : s_reg.prot + 2'h1;
                     end
                  end
                  RT_INIT: if (BTN_CPL_UP) s_next.erase = 1'b1;
                  RT_ADDR: begin
                     if (DELTA_UP && s_reg.addr != ADDR_OFFBUS) begin
                        s_next.addr = s_reg.addr + 5'h01;
                     end else if (DELTA_DN && s_reg.addr != 5'h00) begin
                        s_next.addr = s_reg.addr - 5'h01;
                     end
                  end
                  RT_TERM: begin
                     if (BTN_MODE_UP) s_next.term_lf = ~s_reg.term_lf;
                     if (BTN_CPL_UP) s_next.listen_only = ~s_reg.listen_only;
                  end
                  RT_SYSM: if (BTN_CPL_UP) s_next.sys_m = ~s_reg.sys_m;
                  RT_LINES: if (BTN_CPL_UP) s_next.field1_only = ~s_reg.field1_only;
                  RT_SYNC: begin
                     if (BTN_CPL_UP) begin
                        s_next.sync_pol = (s_reg.sync_pol == SYNC_NEG) ? SYNC_KEEP
                                          : s_reg.sync_pol + 2'h1;
                     end
                  end
                  RT_METER: begin
                     if (s_reg.tone_phase) begin
                        if (SRC_UP && s_reg.tone != TONE_MAX) s_next.tone = s_reg.tone + 4'h1;
                        else if (SRC_DN && s_reg.tone != 4'h0) s_next.tone = s_reg.tone - 4'h1;
                        if (BTN_CPL_UP) s_next.tone_phase = 1'b0;
                     end else if (BTN_CPL_UP) begin
                        s_next.hiz = ~s_reg.hiz;
                     end
                  end
                  default: ;
               endcase
            end
         end
         M_RXREADY: begin
            if (exit_btn) s_next.mode = M_NORMAL;
            else if (BTN_CPL_DN) s_next.mode = M_SELECT;
            else if (XFER_BEGIN && !s_reg.ignore) begin
               s_next.mode   = M_RXBUSY;
               s_next.xstart = 1'b1;
               s_next.xsend  = 1'b0;
            end
         end
         M_RXBUSY: if (XFER_DONE) s_next.mode = M_SELECT;
         M_TXBUSY: if (XFER_DONE) s_next.mode = M_SELECT;
         default: s_next.mode = M_NORMAL;
      endcase
      // hour counter, saturating at four digits
      if (HOUR_TICK && s_reg.hours != COUNT_MAX) s_next.hours = s_reg.hours + 14'h0001;
      // slope forcing on change to line coupling
      if (CPL_AC_TO_TV && s_reg.sync_pol != SYNC_KEEP) begin
         s_next.slope_set = 1'b1;
         s_next.slope_pos = (s_reg.sync_pol == SYNC_POS);
      end
      // save permission
      unique case (s_reg.prot)
         PROT_ALL:  s_next.save_ok = 1'b1;
         PROT_LOW8: s_next.save_ok = !SEQ_EDIT && SAVE_SLOT != 5'h00
                                     && SAVE_SLOT <= LOW8_TOP;
         default:   s_next.save_ok = 1'b0;
      endcase
      // apb slave, one wait state
      s_next.pready  = PSEL && PENABLE && !s_reg.pready;
      s_next.pslverr = 1'b0;
      s_next.prdata  = '0;
      if (PSEL && PENABLE && !s_reg.pready) begin
         unique case (PADDR)
            OFF_SETTINGS: s_next.prdata = set_word;
            OFF_STATUS: begin
               s_next.prdata[F_MODE +: 3] = s_reg.mode;
               s_next.prdata[F_RTN +: 4]  = s_reg.rtn;
            end
            OFF_COUNTERS: begin
               s_next.prdata[F_HRS +: 14] = s_reg.hours;
               s_next.prdata[F_CYC +: 14] = s_reg.cycles;
            end
            default: s_next.pslverr = 1'b1;
         endcase
      end
      if (apb_go && PWRITE) begin
         unique case (PADDR)
            OFF_SETTINGS: begin // restore from nonvolatile image
               s_next.pwr_last    = PWDATA[F_PWR];
               s_next.prot        = PWDATA[F_PROT +: 2];
               s_next.addr        = PWDATA[F_ADDR +: 5];
               s_next.term_lf     = PWDATA[F_LF];
               s_next.listen_only = PWDATA[F_LONLY];
               s_next.sys_m       = PWDATA[F_SYSM];
               s_next.field1_only = PWDATA[F_FLD1];
               s_next.sync_pol    = PWDATA[F_SYNC +: 2];
               s_next.hiz         = PWDATA[F_HIZ];
               s_next.tone        = PWDATA[F_TONE +: 4];
            end
            OFF_COUNTERS: begin
               s_next.hours   = PWDATA[F_HRS +: 14];
               s_next.cycles  = PWDATA[F_CYC +: 14];
               // first restore after power-up counts this power cycle
               if (!s_reg.counted && PWDATA[F_CYC +: 14] != COUNT_MAX) begin
                  s_next.cycles = PWDATA[F_CYC +: 14] + 14'h0001;
               end
               s_next.counted = 1'b1;
            end
            default: ;
         endcase
      end
      // bus behaviour, after any restore; no message end while going off the bus
      s_next.ignore  = (s_next.addr == ADDR_OFFBUS);
      s_next.talk_en = !s_next.listen_only && !s_next.ignore;
      s_next.rx_end  = RX_VALID && !s_reg.ignore && !s_next.ignore
                       && (RX_EOI || (s_reg.term_lf && RX_BYTE == CHAR_LF));
      set_changed    = (s_next.pwr_last != s_reg.pwr_last) || (s_next.prot != s_reg.prot)
                       || (s_next.addr != s_reg.addr) || (s_next.term_lf != s_reg.term_lf)
                       || (s_next.listen_only != s_reg.listen_only)
                       || (s_next.sys_m != s_reg.sys_m)
                       || (s_next.field1_only != s_reg.field1_only)
                       || (s_next.sync_pol != s_reg.sync_pol) || (s_next.hiz != s_reg.hiz)
                       || (s_next.tone != s_reg.tone) || (s_next.hours != s_reg.hours);
      s_next.nv_save = set_changed && !(apb_go && PWRITE);
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         s_reg          <= '0;
         s_reg.mode     <= M_NORMAL;
         s_reg.tone     <= TONE_RST;
         s_reg.talk_en  <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA          = s_reg.prdata;
   assign PREADY          = s_reg.pready;
   assign PSLVERR         = s_reg.pslverr;
   assign DISP_MODE       = s_reg.mode;
   assign DISP_ROUTINE    = s_reg.rtn;
   assign DISP_TONE_PHASE = s_reg.tone_phase;
   assign PWRUP_LAST      = s_reg.pwr_last;
   assign PROT_MODE       = s_reg.prot;
   assign SAVE_OK         = s_reg.save_ok;
   assign ERASE_SETUPS    = s_reg.erase;
   assign BUS_ADDR        = s_reg.addr;
   assign BUS_IGNORE      = s_reg.ignore;
   assign TALK_ENABLE     = s_reg.talk_en;
   assign RX_MSG_END      = s_reg.rx_end;
   assign TX_CRLF         = s_reg.term_lf;
   assign XFER_START      = s_reg.xstart;
   assign XFER_SEND       = s_reg.xsend;
   assign LINE_LEAD       = s_reg.sys_m ? LEAD_SYSM : 2'h0;
   assign FIELD1_ONLY     = s_reg.field1_only;
   assign SLOPE_SET       = s_reg.slope_set;
   assign SLOPE_POS       = s_reg.slope_pos;
   assign METER_HIZ       = s_reg.hiz;
   assign TONE_PITCH      = s_reg.tone;
   assign HOURS           = s_reg.hours;
   assign CYCLES          = s_reg.cycles;
   assign NV_SAVE         = s_reg.nv_save;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   AST_ENTRY: assert property (
      $past(s_reg.mode) == M_NORMAL && s_reg.mode == M_SELECT
      |-> $past(BTN_SLOPE && BTN_VCURSOR && BTN_TCURSOR))
      else $error("monitor entered without the button chord");
   AST_STEP_UP: assert property (
      s_reg.mode == M_SELECT && !exit_btn && BTN_MODE_UP && s_reg.rtn != RT_LAST
      |=> s_reg.rtn == $past(s_reg.rtn) + 4'h1)
      else $error("routine label did not advance");
   AST_LEAVE_RUN: assert property (
      s_reg.mode == M_RUN && BTN_CPL_DN && !exit_btn |=> s_reg.mode == M_SELECT)
      else $error("lower coupling did not return to selection");
   AST_EXIT: assert property (
      (s_reg.mode == M_SELECT || s_reg.mode == M_RUN) && exit_btn |=> s_reg.mode == M_NORMAL)
      else $error("exit button ignored");
   AST_ERASE: assert property (
      ERASE_SETUPS |-> $past(s_reg.mode) == M_RUN && $past(s_reg.rtn) == RT_INIT
      && $past(BTN_CPL_UP))
      else $error("setups erased without request");
   AST_OFFBUS: assert property (
      BUS_IGNORE |-> !TALK_ENABLE && !RX_MSG_END)
      else $error("bus touched at address 31");
   AST_LF_END: assert property (
      RX_VALID && !BUS_IGNORE && TX_CRLF && RX_BYTE == CHAR_LF ##1 !BUS_IGNORE |-> RX_MSG_END)
      else $error("line feed did not end message");
   AST_EOI_ONLY: assert property (
      RX_VALID && !RX_EOI && !TX_CRLF |=> !RX_MSG_END)
      else $error("message ended without EOI");
   AST_LISTEN: assert property (
      s_reg.listen_only |-> ##1 !TALK_ENABLE || !s_reg.listen_only)
      else $error("talker enabled in listen-only");
   AST_RX_DONE: assert property (
      s_reg.mode == M_RXBUSY && XFER_DONE |=> s_reg.mode == M_SELECT ##1 !XFER_START)
      else $error("receive routine did not leave");
   AST_ADDR: assert property (
      s_reg.mode == M_RUN && s_reg.rtn == RT_ADDR && DELTA_UP && !exit_btn && !BTN_CPL_DN
      && !(apb_go && PWRITE) && s_reg.addr == ADDR_OFFBUS |=> BUS_ADDR == ADDR_OFFBUS)
      else $error("address passed 31");
   AST_SLOPE: assert property (
      CPL_AC_TO_TV && s_reg.sync_pol == SYNC_NEG |=> SLOPE_SET && !SLOPE_POS)
      else $error("slope not forced negative");
   AST_CYCLES: assert property (
      apb_go && PWRITE && PADDR == OFF_COUNTERS && !s_reg.counted
      && PWDATA[F_CYC +: 14] != COUNT_MAX
      |=> CYCLES == $past(PWDATA[F_CYC +: 14]) + 14'h0001)
      else $error("power cycle not counted");
   AST_SAVE_LOW8: assert property (
      s_reg.prot == PROT_LOW8 && (SEQ_EDIT || SAVE_SLOT > LOW8_TOP) |=> !SAVE_OK)
      else $error("save allowed outside setups 1 to 8");
endmodule // maint_menu

/* File: shared/menu_pkg.sv */
/*
 * constants, state encodings and the state struct of the maintenance menu.
 * assumes one clock (MCLK, 100 MHz) and a synchronous active-low reset.
 */
// What this block does
// - monitor entered only by slope press while both cursor buttons are held; banner shown.
// - upper or lower mode button steps forward or back through routine labels.
// - upper coupling runs the routine; further presses cycle choices in most routines.
// - lower coupling leaves the running routine back to routine selection.
// - trigger-select, or menu button with counter option, leaves the monitor.
// - powered hours and power cycles counted, four digits each, shown on request.
// - power-up choice between last power-down setup and stored setup one.
// - protection allows all, forbids all, or allows saves into setups 1 to 8 only.
// - in initialize, upper coupling erases all setups, lower coupling leaves them intact.
// - bus address 0 to 31, changed with delta control in the address routine.
// - address 31 makes the device ignore the bus and never drive it.
// - terminator routine: mode button toggles EOI/LF, coupling toggles talk or listen-only.
// - EOI mode ends received messages only on EOI and marks the last sent byte.
// - LF mode ends on EOI or line feed; sending ends CR, LF with EOI.
// - listen-only never lets the device become a talker.
// - transfer routines move all thirty stored setups to one or more receivers.
// - receive shows ready, then receiving, and leaves by itself when done.
// - receiver must be ready first; sender shows sending and leaves by itself.
// - system-M starts line count three lines before field sync, otherwise at it.
// - line numbering restarts every field, or only at field 1.
// - sync default leaves slope, or forces it, on AC to TV-line coupling change.
// - meter routine sets tone pitch by source buttons and low-range input resistance.
package menu_pkg;
   // register byte offsets
   localparam logic [7:0]  OFF_SETTINGS = 8'h00;
   localparam logic [7:0]  OFF_STATUS   = 8'h04;
   localparam logic [7:0]  OFF_COUNTERS = 8'h08;
   // settings, status and counters register field positions
   localparam int          F_PWR    = 0;
   localparam int          F_PROT   = 1;
   localparam int          F_ADDR   = 3;
   localparam int          F_LF     = 8;
   localparam int          F_LONLY  = 9;
   localparam int          F_SYSM   = 10;
   localparam int          F_FLD1   = 11;
   localparam int          F_SYNC   = 12;
   localparam int          F_HIZ    = 14;
   localparam int          F_TONE   = 15;
   localparam int          F_MODE   = 0;
   localparam int          F_RTN    = 3;
   localparam int          F_HRS    = 0;
   localparam int          F_CYC    = 16;
   // routine indices in selection order
   localparam logic [3:0]  RT_HOURS = 4'h0;
   localparam logic [3:0]  RT_PWRUP = 4'h1;
   localparam logic [3:0]  RT_PROT  = 4'h2;
   localparam logic [3:0]  RT_INIT  = 4'h3;
   localparam logic [3:0]  RT_ADDR  = 4'h4;
   localparam logic [3:0]  RT_TERM  = 4'h5;
   localparam logic [3:0]  RT_RECV  = 4'h6;
   localparam logic [3:0]  RT_SEND  = 4'h7;
   localparam logic [3:0]  RT_SYSM  = 4'h8;
   localparam logic [3:0]  RT_LINES = 4'h9;
   localparam logic [3:0]  RT_SYNC  = 4'ha;
   localparam logic [3:0]  RT_METER = 4'hb;
   localparam logic [3:0]  RT_LAST  = 4'hb;
   // values
   localparam logic [4:0]  ADDR_OFFBUS = 5'h1f;
   localparam logic [7:0]  CHAR_LF     = 8'h0a;
   localparam logic [13:0] COUNT_MAX   = 14'h270f;
   localparam logic [3:0]  TONE_MAX    = 4'hf;
   localparam logic [3:0]  TONE_RST    = 4'h8;
   localparam logic [1:0]  LEAD_SYSM   = 2'h3;
   localparam logic [1:0]  PROT_ALL    = 2'h0;
   localparam logic [1:0]  PROT_NONE   = 2'h1;
   localparam logic [1:0]  PROT_LOW8   = 2'h2;
   localparam logic [4:0]  LOW8_TOP    = 5'h08;
   localparam logic [1:0]  SYNC_KEEP   = 2'h0;
   localparam logic [1:0]  SYNC_POS    = 2'h1;
   localparam logic [1:0]  SYNC_NEG    = 2'h2;

   typedef enum logic [2:0] {
      M_NORMAL  = 3'b000,
      M_SELECT  = 3'b001,
      M_RUN     = 3'b010,
      M_RXREADY = 3'b011,
      M_RXBUSY  = 3'b100,
      M_TXBUSY  = 3'b101
   } mode_t;

   typedef struct packed {
      mode_t       mode;
      logic [3:0]  rtn;
      logic        pwr_last;
      logic [1:0]  prot;
      logic [4:0]  addr;
      logic        term_lf;
      logic        listen_only;
      logic        sys_m;
      logic        field1_only;
      logic [1:0]  sync_pol;
      logic        hiz;
      logic [3:0]  tone;
      logic        tone_phase;
      logic [13:0] hours;
      logic [13:0] cycles;
      logic        counted;
      logic        erase;
      logic        xstart;
      logic        xsend;
      logic        rx_end;
      logic        ignore;
      logic        talk_en;
      logic        slope_set;
      logic        slope_pos;
      logic        save_ok;
      logic        nv_save;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;
endpackage

/* File: tb/peer_instrument.sv */
/*
 * peer instrument on the far side of the setup transfer.
 * assumes go, start and send are sampled on rising edges of clk.
 */
module peer_instrument
#(
   parameter int XFER_CYCLES = 30
)
(
   input  wire logic clk,
   input  wire logic go,
   input  wire logic start,
   input  wire logic send,
   output logic      begin_p,
   output logic      done_p
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      begin_p = 1'b0;
      done_p  = 1'b0;
      forever begin
         @(posedge clk);
         if (go || (start && send)) begin
            // as sender, only after the receiver showed ready
            begin_p <= go;
            @(posedge clk);
            begin_p <= 1'b0;
            // one slot per stored setup
            repeat (XFER_CYCLES) @(posedge clk);
            done_p <= 1'b1;
            @(posedge clk);
            done_p <= 1'b0;
         end
      end
   end
endmodule // peer_instrument

/* File: tb/tb.sv */
/*
 * self-checking bench for the maintenance menu, with a peer model.
 * assumes MCLK at 100 MHz and the register map of menu_pkg.
 */
module tb
   import menu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, go, e;
   logic [7:0] PADDR, RX_BYTE;
   logic [31:0] PWDATA, PRDATA, q;
   logic [11:0] pulse;
   logic BTN_VCURSOR, BTN_TCURSOR, BTN_SLOPE, BTN_MODE_UP, BTN_MODE_DN, BTN_CPL_UP, BTN_CPL_DN;
   logic TRIGGER_SELECT_BUTTON, MENU_SELECT_BUTTON, COUNTER_TIMER_OPTION, DELTA_UP, DELTA_DN;
   logic SRC_UP, SRC_DN, HOUR_TICK, XFER_BEGIN, XFER_DONE, RX_VALID, RX_EOI, CPL_AC_TO_TV;
   logic SEQ_EDIT, DISP_TONE_PHASE, PWRUP_LAST, SAVE_OK, ERASE_SETUPS, BUS_IGNORE, TALK_ENABLE;
   logic RX_MSG_END, TX_CRLF, XFER_START, XFER_SEND, FIELD1_ONLY, SLOPE_SET, SLOPE_POS, METER_HIZ;
   logic NV_SAVE;
   logic [4:0] SAVE_SLOT, BUS_ADDR;
   logic [2:0] DISP_MODE;
   logic [3:0] DISP_ROUTINE, TONE_PITCH;
   logic [1:0] PROT_MODE, LINE_LEAD;
   logic [13:0] HOURS, CYCLES;
   int n_errors, num_checks, m_rtn, n, h, n_erase;
   // index: 0 slope,1/2 mode,3/4 coupling,5 trig,6 menu,7/8 delta,9/10 source,11 hour
   assign {HOUR_TICK, SRC_DN, SRC_UP, DELTA_DN, DELTA_UP, MENU_SELECT_BUTTON,
           TRIGGER_SELECT_BUTTON, BTN_CPL_DN, BTN_CPL_UP, BTN_MODE_DN, BTN_MODE_UP,
           BTN_SLOPE} = pulse;
   maint_menu DUT (.*);
   peer_instrument peer (.clk(MCLK), .go(go), .start(XFER_START), .send(XFER_SEND),
                         .begin_p(XFER_BEGIN), .done_p(XFER_DONE));
   always @(posedge MCLK) if (ERASE_SETUPS === 1'b1) n_erase <= n_erase + 1;
   task results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x, input string m);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("Error %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge MCLK);
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= d;
      PSEL <= 1'b1;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      k = 0;
      do begin
         @(posedge MCLK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (k >= 20) begin
         n_errors++;
         results();
      end
   endtask
   task press(input int i);
      @(posedge MCLK);
      pulse[i] <= 1'b1;
      @(posedge MCLK);
      pulse <= '0;
      repeat (2) @(posedge MCLK);
      #1;
   endtask
   task goto(input int r);
      while (m_rtn != r) begin
         press(1);
         m_rtn = (m_rtn + 1) % 12;
         chk(DISP_ROUTINE, m_rtn, "routine");
      end
   endtask
   task run2(input int r);
      goto(r);
      repeat (2) press(3);
   endtask
   task wmode(input logic [2:0] x);
      int k;
      k = 0;
      while (DISP_MODE !== x && k < 200) begin
         @(posedge MCLK);
         k++;
      end
      #1;
      chk(DISP_MODE, x, "mode");
      if (k >= 200) results();
   endtask
   task rx(input logic [7:0] b, input logic eo, input logic x);
      logic seen;
      @(posedge MCLK);
      RX_BYTE <= b;
      RX_EOI <= eo;
      RX_VALID <= 1'b1;
      @(posedge MCLK);
      RX_VALID <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         @(posedge MCLK);
         seen = seen | (RX_MSG_END === 1'b1);
      end
      chk(seen, x, "message end");
   endtask
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial begin
      {PSEL, PENABLE, PWRITE, RX_VALID, RX_EOI, go, CPL_AC_TO_TV, SEQ_EDIT} = '0;
      {BTN_VCURSOR, BTN_TCURSOR, COUNTER_TIMER_OPTION} = '0;
      PADDR = '0;
      PWDATA = '0;
      RX_BYTE = '0;
      SAVE_SLOT = 5'h01;
      pulse = '0;
      RST_B = 1'b0;
      n = $urandom(32'h8e0471a1);
      repeat (10) @(posedge MCLK);
      RST_B <= 1'b1;
      apb(OFF_SETTINGS, 1'b0, 32'h0);
      chk(q, 32'(TONE_RST) << F_TONE, "settings reset");
      apb(8'h0c, 1'b0, 32'h0);
      chk(e, 1'b1, "unmapped");
      h = $urandom % 9000;
      apb(OFF_COUNTERS, 1'b1, (32'(h) << F_CYC) | 32'(h));
      apb(OFF_COUNTERS, 1'b0, 32'h0);
      chk(q, (32'(h + 1) << F_CYC) | 32'(h), "counters");
      press(0);
      chk(DISP_MODE, M_NORMAL, "slope alone");
      @(posedge MCLK);
      BTN_VCURSOR <= 1'b1;
      BTN_TCURSOR <= 1'b1;
      press(0);
      chk(DISP_MODE, M_SELECT, "banner");
      apb(OFF_STATUS, 1'b0, 32'h0);
      chk(q, 32'(M_SELECT), "status");
      $display("test entry done");
      m_rtn = 0;
      goto(1);
      press(3);
      chk(DISP_MODE, M_RUN, "run");
      press(3);
      chk(PWRUP_LAST, 1'b1, "power-up choice");
      press(4);
      chk(DISP_MODE, M_SELECT, "leave");
      run2(2);
      press(3);
      chk(PROT_MODE, PROT_LOW8, "protection");
      n = 1 + $urandom % 30;
      @(posedge MCLK);
      SAVE_SLOT <= 5'(n);
      repeat (2) @(posedge MCLK);
      #1;
      chk(SAVE_OK, n <= LOW8_TOP, "save slot");
      press(3);
      press(4);
      goto(3);
      press(3);
      press(4);
      run2(3);
      press(4);
      chk(n_erase, 1, "erase");
      goto(4);
      press(3);
      n = 3 + $urandom % 8;
      repeat (n) press(7);
      chk(BUS_ADDR, n, "address");
      repeat (35) press(7);
      chk(BUS_ADDR, ADDR_OFFBUS, "address top");
      chk(BUS_IGNORE, 1'b1, "off bus");
      rx(8'h41, 1'b1, 1'b0);
      press(8);
      press(4);
      $display("test address done");
      rx(CHAR_LF, 1'b0, 1'b0);
      rx(8'h20 + 8'($urandom % 64), 1'b1, 1'b1);
      goto(5);
      press(3);
      press(1);
      chk(TX_CRLF, 1'b1, "lf mode");
      rx(CHAR_LF, 1'b0, 1'b1);
      press(3);
      chk(TALK_ENABLE, 1'b0, "listen only");
      press(4);
      goto(7);
      press(3);
      chk(DISP_MODE, M_SELECT, "send refused");
      run2(5);
      chk(TALK_ENABLE, 1'b1, "talk back");
      press(4);
      goto(6);
      press(3);
      wmode(M_RXREADY);
      @(posedge MCLK);
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      wmode(M_RXBUSY);
      wmode(M_SELECT);
      goto(7);
      press(3);
      chk(DISP_MODE, M_TXBUSY, "sending");
      wmode(M_SELECT);
      $display("test transfer done");
      run2(8);
      chk(LINE_LEAD, LEAD_SYSM, "system-M lead");
      press(4);
      run2(9);
      chk(FIELD1_ONLY, 1'b1, "field 1 only");
      press(4);
      run2(10);
      @(posedge MCLK);
      CPL_AC_TO_TV <= 1'b1;
      @(posedge MCLK);
      CPL_AC_TO_TV <= 1'b0;
      #1;
      chk({SLOPE_SET, SLOPE_POS}, 2'b11, "slope forced");
      press(4);
      goto(11);
      press(3);
      press(9);
      chk(TONE_PITCH, TONE_RST + 4'h1, "tone");
      repeat (2) press(3);
      chk(METER_HIZ, 1'b1, "input resistance");
      press(4);
      press(5);
      chk(DISP_MODE, M_NORMAL, "exit");
      repeat (3) press(11);
      chk(HOURS, h + 3, "hours");
      $display("test exit done");
      results();
   end
endmodule // tb
